/* shared/serial_link_consts.svh */
`ifndef SERIAL_LINK_CONSTS_SVH
`define SERIAL_LINK_CONSTS_SVH

// Framing
`define MB_BLOCKS 6'd32
`define MB_LAST 5'd31
`define LMFC_LAST 5'd15
`define PILOT 5'b00001
`define EOEMB_POS 5'd22
`define ILAS_MF_LAST 2'd3
`define HDR_ONE 2'b01
`define HDR_ZERO 2'b10

// Fill words
`define CGS_WORD 64'hBCBC_BCBC_BCBC_BCBC
`define ILAS_WORD 64'h1C1C_1C1C_1C1C_1C1C
`define IDLE_WORD 64'h0000_0000_0000_0000

// Alarm bit positions
`define ALM_CPLL 0
`define ALM_SPLL 1
`define ALM_LINK 2
`define ALM_SYSREF 3
`define ALM_CLK 4
`define ALM_FIFO 5
`define ALM_RESET 6'h00

// Receiver monitor thresholds
`define SH_WINDOW 6'd63
`define SH_ERR_LIMIT 4'd4
`define SH_LOCK_GOOD 6'd63
`define MB_WINDOW 4'd15
`define MB_ERR_LIMIT 3'd3
`define EMB_ERR_LIMIT 3'd3

`endif

/* shared/serial_link_pkg.sv */
package serial_link_pkg;
    typedef enum logic [1:0] {
        TX_OFF = 2'b00,
        TX_CGS = 2'b01,
        TX_ILAS = 2'b11,
        TX_DATA = 2'b10
    } tx_state_t;
    typedef enum logic [1:0] {
        CF_IDLE = 2'b00,
        CF_LOAD = 2'b01,
        CF_ARM = 2'b11
    } cfg_state_t;
    typedef logic [63:0] word_t;
endpackage : serial_link_pkg

/* shared/serial_link_if.sv */
interface serial_link_if;
    logic [1:0] hdr;
    logic [63:0] payload;
    logic txValid;
    logic rxReady;
    logic syncN;
    logic linkEnable;
    logic encMode;
    logic subclass0;
    logic [3:0] preemphasis;
    modport dev (
        input rxReady, syncN, linkEnable, encMode, subclass0, preemphasis,
        output hdr, payload, txValid
    );
    modport host (
        output rxReady, syncN, linkEnable, encMode, subclass0, preemphasis,
        input hdr, payload, txValid
    );
endinterface : serial_link_if

/* verilog/serial_link_rx_host.sv */
`include "serial_link_consts.svh"

module serial_link_rx_host
    import serial_link_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Link
    serial_link_if.host link,
    // Configuration
    input wire logic cfgReq,
    input wire logic cfgEncMode,
    input wire logic cfgSubclass0,
    input wire logic [3:0] cfgPreemph,
    input wire logic [4:0] cfgRbd,
    // System timing
    input wire logic sysrefDone,
    output logic sysrefReq_r,
    // Data out
    input wire logic userReady,
    output word_t dataOut_r,
    output logic dataValid_r,
    // Status
    output logic blockLock_r,
    output logic mbLock_r,
    output logic embLock_r,
    output logic released_r
);
    cfg_state_t cfgState_r;
    logic linkEnable_r, encMode_r, subclass0_r, rxReady_r, syncN_r;
    logic [3:0] preemph_r;
    logic [4:0] rbd_r;
    logic [5:0] winCnt_r, goodCnt_r;
    logic [3:0] shErr_r, mbWin_r;
    logic [2:0] mbErr_r, embErr_r;
    logic [31:0] shReg_r;
    logic [4:0] mbPos_r, rxLemc_r;
    logic waitSys_r;

    assign link.linkEnable = linkEnable_r;
    assign link.encMode = encMode_r;
    assign link.subclass0 = subclass0_r;
    assign link.preemphasis = preemph_r;
    assign link.rxReady = rxReady_r;
    assign link.syncN = syncN_r;

    wire take = link.txValid && rxReady_r;
    wire shOk = link.hdr[1] ^ link.hdr[0];
    wire shBit = link.hdr[0];
    wire winEnd = (winCnt_r == `SH_WINDOW);
    wire loseBlock = blockLock_r && !shOk && (shErr_r + 4'd1 >= `SH_ERR_LIMIT);
    wire pilotOk = ({shReg_r[3:0], shBit} == `PILOT);
    wire mbEnd = mbLock_r && (mbPos_r == `MB_LAST);
    wire loseMb = mbEnd && !pilotOk && (mbErr_r + 3'd1 >= `MB_ERR_LIMIT);
    wire eoembBad = mbEnd && !shReg_r[8];
    wire loseEmb = eoembBad && (embErr_r + 3'd1 >= `EMB_ERR_LIMIT);
    wire loseAny = loseMb || loseEmb || loseBlock;

    // ----------------------------------------
    // Configuration sequencing
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfgState_r <= CF_IDLE;
            linkEnable_r <= 1'b0;
            encMode_r <= 1'b1;
            subclass0_r <= 1'b0;
            preemph_r <= 4'h0;
            rbd_r <= 5'h00;
        end else if (ce) begin
            case (cfgState_r)
                CF_IDLE: if (cfgReq) begin
                    linkEnable_r <= 1'b0;
                    cfgState_r <= CF_LOAD;
                end
                CF_LOAD: begin
                    encMode_r <= cfgEncMode;
                    subclass0_r <= cfgSubclass0;
                    preemph_r <= cfgPreemph;
                    rbd_r <= cfgRbd;
                    cfgState_r <= CF_ARM;
                end
                CF_ARM: begin
                    linkEnable_r <= 1'b1;
                    cfgState_r <= CF_IDLE;
                end
                default: cfgState_r <= CF_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Flow control and sync request
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rxReady_r <= 1'b0;
            syncN_r <= 1'b0;
            dataOut_r <= `IDLE_WORD;
            dataValid_r <= 1'b0;
        end else if (ce) begin
            rxReady_r <= userReady;
            syncN_r <= linkEnable_r && (cfgState_r == CF_IDLE);
            dataValid_r <= take && released_r;
            if (take)
                dataOut_r <= link.payload;
        end
    end

    // ----------------------------------------
    // Block alignment
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            blockLock_r <= 1'b0;
            winCnt_r <= 6'h00;
            goodCnt_r <= 6'h00;
            shErr_r <= 4'h0;
        end else if (ce) begin
            if (!linkEnable_r) begin
                blockLock_r <= 1'b0;
                goodCnt_r <= 6'h00;
                shErr_r <= 4'h0;
                winCnt_r <= 6'h00;
            end else if (take) begin
                winCnt_r <= winEnd ? 6'h00 : winCnt_r + 6'd1;
                if (!blockLock_r) begin
                    goodCnt_r <= shOk ? goodCnt_r + 6'd1 : 6'h00;
                    blockLock_r <= shOk && (goodCnt_r == `SH_LOCK_GOOD);
                    shErr_r <= 4'h0;
                end else if (loseBlock) begin
                    blockLock_r <= 1'b0;
                    goodCnt_r <= 6'h00;
                    shErr_r <= 4'h0;
                end else if (winEnd) begin
                    shErr_r <= 4'h0;
                end else if (!shOk) begin
                    shErr_r <= shErr_r + 4'd1;
                end
            end
        end
    end

    // ----------------------------------------
    // Multiblock and extended multiblock
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shReg_r <= 32'h0000_0000;
            mbPos_r <= 5'h00;
            mbLock_r <= 1'b0;
            embLock_r <= 1'b0;
            mbErr_r <= 3'h0;
            embErr_r <= 3'h0;
            mbWin_r <= 4'h0;
            waitSys_r <= 1'b0;
            sysrefReq_r <= 1'b0;
        end else if (ce) begin
            sysrefReq_r <= 1'b0;
            if (sysrefDone)
                waitSys_r <= 1'b0;
            if (!linkEnable_r) begin
                mbLock_r <= 1'b0;
                embLock_r <= 1'b0;
                waitSys_r <= 1'b0;
            end else if (take) begin
                shReg_r <= {shReg_r[30:0], shBit};
                mbPos_r <= mbPos_r + 5'd1;
                if (loseAny || !blockLock_r) begin
                    mbLock_r <= 1'b0;
                    embLock_r <= 1'b0;
                    mbErr_r <= 3'h0;
                    embErr_r <= 3'h0;
                    if (loseMb || loseEmb) begin
                        sysrefReq_r <= 1'b1;
                        waitSys_r <= 1'b1;
                    end
                end else if (!mbLock_r) begin
                    if (pilotOk && !waitSys_r && !sysrefDone) begin
                        mbLock_r <= 1'b1;
                        embLock_r <= shReg_r[8];
                        mbPos_r <= 5'h00;
                        mbWin_r <= 4'h0;
                    end
                end else if (mbEnd) begin
                    embLock_r <= embLock_r | shReg_r[8];
                    mbWin_r <= mbWin_r + 4'd1;
                    if (mbWin_r == `MB_WINDOW) begin
                        mbErr_r <= 3'h0;
                        embErr_r <= 3'h0;
                    end else begin
                        mbErr_r <= mbErr_r + {2'b00, !pilotOk};
                        embErr_r <= embErr_r + {2'b00, eoembBad};
                    end
                end
            end
        end
    end

    // ----------------------------------------
    // Elastic release point
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rxLemc_r <= 5'h00;
            released_r <= 1'b0;
        end else if (ce) begin
            if (sysrefDone)
                rxLemc_r <= 5'h00;
            else if (take)
                rxLemc_r <= rxLemc_r + 5'd1;
            if (!embLock_r)
                released_r <= 1'b0;
            else if (take && rxLemc_r == rbd_r)
                released_r <= 1'b1;
        end
    end
endmodule : serial_link_rx_host

/* verilog/serial_link_tx_device.sv */
`include "serial_link_consts.svh"

module serial_link_tx_device
    import serial_link_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Link
    serial_link_if.dev link,
    // Data in
    input word_t inData,
    input wire logic inValid,
    output logic inReady_r,
    // Timing and alarm pins
    input wire logic sysrefPin,
    input wire logic cpllUnlocked,
    input wire logic spllUnlocked,
    input wire logic clockUpset,
    input wire logic fifoError,
    // Alarm control
    input wire logic [5:0] alarmClear,
    input wire logic [5:0] alarm_mask_bits,
    input wire logic pinSelAlarm,
    input wire logic calStatus,
    // Status and analog controls
    output logic [5:0] alarm_status_bits,
    output logic alarmSummary_r,
    output logic cal_or_alarm_output_pin,
    output logic [3:0] serializer_preemphasis_level,
    output logic serPowerDown_r,
    output logic clkGateEn_r,
    output logic lemcEdge_r
);
    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function automatic logic [4:0] lastCount(input logic mode);
        lastCount = mode ? `MB_LAST : `LMFC_LAST;
    endfunction : lastCount

    function automatic logic streamBit(input logic [4:0] pos);
        case (pos)
            5'd3, 5'd7, 5'd11, 5'd15, 5'd19, 5'd21, 5'd23, 5'd31: streamBit = 1'b1;
            `EOEMB_POS: streamBit = 1'b1;
            default: streamBit = 1'b0;
        endcase
    endfunction : streamBit

    tx_state_t state_r;
    logic [6:0] s1_r, s2_r, s3_r, filt_r;
    logic sysrefPrev_r;
    logic [4:0] lemc_r;
    logic [1:0] ilasCnt_r;
    logic [1:0] hdr_r;
    word_t payload_r;
    logic txValid_r;
    word_t mem_r [2];
    logic wrPtr_r, rdPtr_r;
    logic [1:0] count_r;
    logic [5:0] status_r;
    logic pin_r;
    logic [3:0] preemph_r;

    assign link.hdr = hdr_r;
    assign link.payload = payload_r;
    assign link.txValid = txValid_r;
    assign alarm_status_bits = status_r;
    assign cal_or_alarm_output_pin = pin_r;
    assign serializer_preemphasis_level = preemph_r;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    wire [6:0] pins = {sysrefPin, fifoError, clockUpset, 2'b00, spllUnlocked, cpllUnlocked};
    wire [6:0] agree = ~(s2_r ^ s3_r);
    wire [6:0] filtNxt = (filt_r & ~agree) | (s3_r & agree);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_r <= 7'h00;
            s2_r <= 7'h00;
            s3_r <= 7'h00;
            filt_r <= 7'h00;
            sysrefPrev_r <= 1'b0;
        end else if (ce) begin
            s1_r <= pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
            filt_r <= filtNxt;
            sysrefPrev_r <= filt_r[6];
        end
    end

    // ----------------------------------------
    // Local multiframe clock
    // ----------------------------------------
    wire en = link.linkEnable;
    wire mode = link.encMode;
    wire sysEdge = filt_r[6] && !sysrefPrev_r && !link.subclass0;
    wire lemcWrap = (lemc_r == lastCount(mode));
    wire realign = sysEdge && en && !lemcWrap;
    wire step = link.rxReady && en;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lemc_r <= 5'h00;
            lemcEdge_r <= 1'b0;
        end else if (ce) begin
            if (!en) begin
                lemc_r <= 5'h00;
                lemcEdge_r <= 1'b0;
            end else if (sysEdge) begin
                lemc_r <= 5'h00;
                lemcEdge_r <= 1'b1;
            end else if (step) begin
                lemc_r <= lemcWrap ? 5'h00 : lemc_r + 5'd1;
                lemcEdge_r <= lemcWrap;
            end else begin
                lemcEdge_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Link state
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= TX_OFF;
            ilasCnt_r <= 2'h0;
        end else if (ce) begin
            if (!en) begin
                state_r <= TX_OFF;
            end else begin
                case (state_r)
                    TX_OFF: state_r <= TX_CGS;
                    TX_CGS: if (step && lemcWrap && (mode || link.syncN)) begin
                        state_r <= mode ? TX_DATA : TX_ILAS;
                        ilasCnt_r <= 2'h0;
                    end
                    TX_ILAS: if (!link.syncN) begin
                        state_r <= TX_CGS;
                    end else if (step && lemcWrap) begin
                        ilasCnt_r <= ilasCnt_r + 2'd1;
                        if (ilasCnt_r == `ILAS_MF_LAST)
                            state_r <= TX_DATA;
                    end
                    TX_DATA: if (!mode && !link.syncN)
                        state_r <= TX_CGS;
                    default: state_r <= TX_OFF;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Two-entry buffer
    // ----------------------------------------
    wire push = inValid && inReady_r;
    wire pop = step && (state_r == TX_DATA) && (count_r != 2'd0);
    wire [1:0] countNxt = count_r + {1'b0, push} - {1'b0, pop};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrPtr_r <= 1'b0;
            rdPtr_r <= 1'b0;
            count_r <= 2'd0;
            inReady_r <= 1'b0;
        end else if (ce) begin
            if (push)
                wrPtr_r <= !wrPtr_r;
            if (pop)
                rdPtr_r <= !rdPtr_r;
            count_r <= countNxt;
            inReady_r <= (countNxt != 2'd2);
        end
    end

    always_ff @(posedge clk) begin
        if (ce && push)
            mem_r[wrPtr_r] <= inData;
    end

    // ----------------------------------------
    // Block output
    // ----------------------------------------
    wire shb = streamBit(lemc_r);
    wire [1:0] hdrNxt = shb ? `HDR_ONE : `HDR_ZERO;
    wire word_t dataWord = (count_r != 2'd0) ? mem_r[rdPtr_r] : `IDLE_WORD;
    wire word_t fillWord = (state_r == TX_ILAS) ? `ILAS_WORD : `CGS_WORD;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hdr_r <= `HDR_ONE;
            payload_r <= `IDLE_WORD;
            txValid_r <= 1'b0;
        end else if (ce) begin
            txValid_r <= en && (state_r != TX_OFF);
            if (step) begin
                hdr_r <= hdrNxt;
                payload_r <= (state_r == TX_DATA) ? dataWord : fillWord;
            end
        end
    end

    // ----------------------------------------
    // Alarms and analog controls
    // ----------------------------------------
    wire [5:0] events = {filt_r[5], filt_r[4], realign, en && (state_r != TX_DATA), filt_r[1], filt_r[0]};
    wire [5:0] statusNxt = (status_r & ~alarmClear) | events;
    wire summaryNxt = |(statusNxt & ~alarm_mask_bits);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_r <= `ALM_RESET;
            alarmSummary_r <= 1'b0;
            pin_r <= 1'b0;
            preemph_r <= 4'h0;
            serPowerDown_r <= 1'b1;
            clkGateEn_r <= 1'b0;
        end else if (ce) begin
            status_r <= statusNxt;
            alarmSummary_r <= summaryNxt;
            pin_r <= pinSelAlarm ? summaryNxt : calStatus;
            preemph_r <= en ? link.preemphasis : 4'h0;
            serPowerDown_r <= !en;
            clkGateEn_r <= en;
        end
    end
endmodule : serial_link_tx_device

/* verif/serial_link_sync_and_alarms_asserts.sv */
`include "serial_link_consts.svh"

module serial_link_sync_and_alarms_asserts
    import serial_link_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Link
    input wire logic [1:0] hdr,
    input wire logic [63:0] payload,
    input wire logic txValid,
    input wire logic rxReady,
    input wire logic syncN,
    input wire logic linkEnable,
    input wire logic encMode,
    input wire logic subclass0,
    input wire logic [3:0] preemphasis
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ------------------------------
    // Header stream run lengths
    // ------------------------------
    logic blkTaken;
    logic [3:0] zeroRun_r;
    logic [3:0] oneRun_r;
    assign blkTaken = txValid && rxReady && linkEnable && encMode;
    always_ff @(posedge clk) begin
        if (rst || !linkEnable) begin
            zeroRun_r <= 4'h0;
            oneRun_r <= 4'h0;
        end else if (blkTaken) begin
            zeroRun_r <= hdr[0] ? 4'h0 : zeroRun_r + 4'(zeroRun_r != 4'hF);
            oneRun_r <= !hdr[0] ? 4'h0 : oneRun_r + 4'(oneRun_r != 4'hF);
        end
    end
    // ------------------------------
    // Properties
    // ------------------------------
    AST_HDR_TRANS: assert property (txValid |-> (hdr == `HDR_ONE || hdr == `HDR_ZERO))
        else $error("sync header is not a transition");
    AST_ZERO_RUN: assert property (zeroRun_r <= 4'h7)
        else $error("header stream zero run too long");
    AST_ONE_RUN: assert property (oneRun_r <= 4'h3)
        else $error("header stream one run too long");
    AST_OFF_IDLE: assert property (!linkEnable && $past(!linkEnable) |-> !txValid)
        else $error("block sent while link disabled");
    AST_CGS_ON_SYNC: assert property (linkEnable && !encMode && txValid && !$past(txValid)
        |-> payload == `CGS_WORD)
        else $error("link did not start with CGS");
    AST_CGS_TO_ILAS: assert property (!encMode && linkEnable && $past(linkEnable) && txValid
        && $past(txValid) && $past(payload) == `CGS_WORD && payload != `CGS_WORD |-> payload == `ILAS_WORD)
        else $error("CGS not followed by ILAS");
    AST_NO_ILAS_64: assert property (encMode && txValid |-> payload != `ILAS_WORD)
        else $error("ILAS sent in 64B mode");
    AST_CFG_QUIET: assert property ($changed(encMode) || $changed(subclass0) || $changed(preemphasis)
        |-> !linkEnable && !$past(linkEnable))
        else $error("config changed while link enabled");
    AST_EN_GAP: assert property ($fell(linkEnable) |-> !linkEnable [*2] ##1 linkEnable)
        else $error("enable gap not two cycles");
    AST_SYNCN_EN: assert property ($rose(syncN) |-> linkEnable && $past(linkEnable))
        else $error("SYNC released before link enabled");
    cover property ($rose(linkEnable) && encMode);
    cover property (txValid && payload == `ILAS_WORD);
    cover property (blkTaken && zeroRun_r == 4'h7 && hdr[0]);
    cover property ($fell(linkEnable));
endmodule : serial_link_sync_and_alarms_asserts

/* verif/serial_link_sync_and_alarms_test.sv */
`include "serial_link_consts.svh"

module serial_link_sync_and_alarms_test
    import serial_link_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst, ce, inValid, sysrefPin, pinSelAlarm, calStatus, cfgReq, cfgEncMode, cfgSubclass0, userReady;
    logic inReady_r, alarmSummary_r, cal_or_alarm_output_pin, serPowerDown_r, clkGateEn_r, lemcEdge_r;
    logic sysrefReq_r, dataValid_r, blockLock_r, mbLock_r, embLock_r, released_r;
    logic sysrefDone = 1'b0;
    logic [3:0] alarmSrc, cfgPreemph, serializer_preemphasis_level;
    logic [5:0] alarmClear, alarm_mask_bits, alarm_status_bits;
    logic [4:0] cfgRbd;
    word_t inData, dataOut_r;
    int fails = 0;
    int comparisons = 0;

    serial_link_if sl_if ();
    serial_link_tx_device serial_link_tx_device_i (.clk(clk), .rst(rst), .ce(ce), .link(sl_if.dev),
        .inData(inData), .inValid(inValid), .inReady_r(inReady_r), .sysrefPin(sysrefPin),
        .cpllUnlocked(alarmSrc[0]), .spllUnlocked(alarmSrc[1]), .clockUpset(alarmSrc[2]),
        .fifoError(alarmSrc[3]), .alarmClear(alarmClear), .alarm_mask_bits(alarm_mask_bits),
        .pinSelAlarm(pinSelAlarm), .calStatus(calStatus), .alarm_status_bits(alarm_status_bits),
        .alarmSummary_r(alarmSummary_r), .cal_or_alarm_output_pin(cal_or_alarm_output_pin),
        .serializer_preemphasis_level(serializer_preemphasis_level), .serPowerDown_r(serPowerDown_r),
        .clkGateEn_r(clkGateEn_r), .lemcEdge_r(lemcEdge_r));
    serial_link_rx_host serial_link_rx_host_i (.clk(clk), .rst(rst), .ce(ce), .link(sl_if.host),
        .cfgReq(cfgReq), .cfgEncMode(cfgEncMode), .cfgSubclass0(cfgSubclass0), .cfgPreemph(cfgPreemph),
        .cfgRbd(cfgRbd), .sysrefDone(sysrefDone), .sysrefReq_r(sysrefReq_r), .userReady(userReady),
        .dataOut_r(dataOut_r), .dataValid_r(dataValid_r), .blockLock_r(blockLock_r), .mbLock_r(mbLock_r),
        .embLock_r(embLock_r), .released_r(released_r));
    serial_link_sync_and_alarms_asserts serial_link_sync_and_alarms_asserts_i (.clk(clk), .rst(rst),
        .hdr(sl_if.hdr), .payload(sl_if.payload), .txValid(sl_if.txValid), .rxReady(sl_if.rxReady),
        .syncN(sl_if.syncN), .linkEnable(sl_if.linkEnable), .encMode(sl_if.encMode),
        .subclass0(sl_if.subclass0), .preemphasis(sl_if.preemphasis));

    always #4 clk = ~clk;
    // Answer each SYSREF request one clock later
    always @(posedge clk) sysrefDone <= #1 sysrefReq_r;

    // ------------------------------
    // Helpers
    // ------------------------------
    task automatic tally_and_finish();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    function automatic logic sel(input int which);
        case (which)
            0: return released_r;
            1: return lemcEdge_r;
            2: return sl_if.payload === `ILAS_WORD;
            3: return sl_if.linkEnable;
            5: return inReady_r;
            default: return !sl_if.linkEnable;
        endcase
    endfunction : sel
    task automatic wait_on(input int which, input int lim);
        int n;
        for (n = 0; sel(which) !== 1'b1; n++) begin
            if (n == lim) begin
                chk("wait", 1, 0);
                tally_and_finish();
            end
            step(1);
        end
    endtask : wait_on
    task automatic push(input word_t w);
        inData = w;
        inValid = 1'b1;
        wait_on(5, 50);
        step(1);
    endtask : push
    task automatic configure(input logic enc, input logic sc0, input logic [3:0] pe);
        cfgEncMode = enc;
        cfgSubclass0 = sc0;
        cfgPreemph = pe;
        cfgReq = 1'b1;
        step(1);
        cfgReq = 1'b0;
        wait_on(4, 4);
        step(1);
        chk("serPowerDown_r", 1, serPowerDown_r);
        wait_on(3, 4);
        step(3);
        chk("serPowerDown_r", 0, serPowerDown_r);
        chk("clkGateEn_r", 1, clkGateEn_r);
        chk("preemphasis", pe, serializer_preemphasis_level);
    endtask : configure
    task automatic clear_all();
        alarmClear = 6'h3F;
        step(1);
        alarmClear = 6'h00;
        step(2);
    endtask : clear_all

    // ------------------------------
    // Scenarios
    // ------------------------------
    task automatic t_disabled();
        chk("serPowerDown_r", 1, serPowerDown_r);
        chk("clkGateEn_r", 0, clkGateEn_r);
        chk("preemphasis", 0, serializer_preemphasis_level);
    endtask : t_disabled
    task automatic t_data64();
        word_t q[$];
        word_t exp [3] = '{64'h1111_2222_3333_4444, 64'h5555_6666_7777_8888, 64'h9999_AAAA_BBBB_CCCC};
        int n;
        configure(1'b1, 1'b0, 4'hA);
        wait_on(0, 600);
        chk("locks", 4'hE, {blockLock_r, mbLock_r, embLock_r, sysrefReq_r});
        chk("linkAlarm", 1, alarm_status_bits[`ALM_LINK]);
        userReady = 1'b0;
        step(2);
        push(exp[0]);
        push(exp[1]);
        inValid = 1'b0;
        step(3);
        chk("inReady_r", 0, inReady_r);
        userReady = 1'b1;
        push(exp[2]);
        inValid = 1'b0;
        for (n = 0; n < 60 && q.size() < 3; n++) begin
            if (dataValid_r === 1'b1 && dataOut_r !== 64'h0) q.push_back(dataOut_r);
            step(1);
        end
        chk("words", 3, q.size());
        foreach (q[i]) chk("dataOut_r", exp[i], q[i]);
    endtask : t_data64
    task automatic t_alarms();
        int idx [4] = '{`ALM_CPLL, `ALM_SPLL, `ALM_CLK, `ALM_FIFO};
        pinSelAlarm = 1'b1;
        clear_all();
        chk("status", 0, alarm_status_bits);
        for (int i = 0; i < 4; i++) begin
            alarm_mask_bits = 6'h3F;
            alarmSrc[i] = 1'b1;
            step(8);
            alarmSrc[i] = 1'b0;
            step(8);
            chk("status", 6'h01 << idx[i], alarm_status_bits);
            chk("summary", 0, alarmSummary_r);
            chk("pin", 0, cal_or_alarm_output_pin);
            alarm_mask_bits = 6'h00;
            step(2);
            chk("summary", 1, alarmSummary_r);
            chk("pin", 1, cal_or_alarm_output_pin);
            clear_all();
            chk("status", 0, alarm_status_bits);
        end
        alarmSrc[0] = 1'b1;
        step(8);
        alarmClear = 6'h01;
        step(1);
        alarmClear = 6'h00;
        chk("status", 1, alarm_status_bits[`ALM_CPLL]);
        alarmSrc[0] = 1'b0;
        step(8);
        clear_all();
        pinSelAlarm = 1'b0;
        calStatus = 1'b1;
        step(2);
        chk("pin", 1, cal_or_alarm_output_pin);
    endtask : t_alarms
    task automatic t_sysref();
        int n;
        configure(1'b0, 1'b0, 4'h3);
        wait_on(2, 400);
        clear_all();
        wait_on(1, 40);
        step(5);
        sysrefPin = 1'b1;
        wait_on(1, 12);
        step(1);
        for (n = 1; n < 40 && lemcEdge_r !== 1'b1; n++) step(1);
        chk("lmfcPeriod", `LMFC_LAST + 1, n);
        sysrefPin = 1'b0;
        step(4);
        chk("realign", 1, alarm_status_bits[`ALM_SYSREF]);
        configure(1'b0, 1'b1, 4'h3);
        clear_all();
        sysrefPin = 1'b1;
        step(8);
        sysrefPin = 1'b0;
        step(4);
        chk("realign", 0, alarm_status_bits[`ALM_SYSREF]);
        wait_on(1, 17);
    endtask : t_sysref

    initial begin
        #800000;
        chk("watchdog", 1, 0);
        tally_and_finish();
    end
    initial begin
        {clk, ce, inValid, sysrefPin, pinSelAlarm, calStatus, cfgReq, cfgEncMode, cfgSubclass0} = '0;
        {alarmSrc, cfgPreemph, alarmClear, alarm_mask_bits, inData} = '0;
        cfgRbd = 5'h02;
        userReady = 1'b1;
        rst = 1'b1;
        ce = 1'b1;
        repeat (8) @(posedge clk);
        #1 rst = 1'b0;
        step(1);
        t_disabled();
        t_data64();
        t_alarms();
        t_sysref();
        tally_and_finish();
    end
endmodule : serial_link_sync_and_alarms_test
